//--- pwt_fifo_model.sv
// behavioural waveform executor and slave fifo flag model
`timescale 1ns/100ps
module pwt_fifo_model (
  // executor handshake
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic        fifo_in,
  input  wire logic [1:0]  kind_in,
  input  wire logic [2:0]  lat_in,
  output logic             done_out,
  // fill levels and lanes
  input  wire logic [6:0]  lim_in,
  input  wire logic        clr_in,
  output logic      [3:0]  flags_out,
  output logic      [15:0] cap_out,
  output logic      [7:0]  lo_out,
  output logic      [7:0]  hi_out
);
  logic [6:0] fill [4] = '{default: 7'h0};
  logic [2:0] cnt      = 3'h0;
  initial done_out = 1'b0;
  initial cap_out = 16'h0;
  // lanes show the inverse outside the capture cycle
  assign lo_out = done_out ? cap_out[7:0] : ~cap_out[7:0];
  assign hi_out = done_out ? cap_out[15:8] : ~cap_out[15:8];
  assign flags_out = {fill[3] >= lim_in, fill[2] >= lim_in,
                      fill[1] >= lim_in, fill[0] >= lim_in};
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (clr_in) fill <= '{default: 7'h0};
    if (start_in) begin
      cnt <= lat_in;
      cap_out <= 16'($urandom);
      if (fifo_in) fill[kind_in] <= fill[kind_in] + 7'h1;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      done_out <= cnt == 3'h1;
    end
  end
endmodule

//--- pwt_pkg.sv
// shared constants for the waveform trigger and dispatch block
package pwt_pkg;
  localparam logic [15:0] WF_SEL_ADDR     = 16'h7824;
  localparam logic [15:0] IDLE_CS_ADDR    = 16'h7825;
  localparam logic [15:0] DAT_HIGH_ADDR   = 16'h7828;
  localparam logic [15:0] DAT_LTRIG_ADDR  = 16'h7829;
  localparam logic [15:0] DAT_LPEEK_ADDR  = 16'h782a;
  localparam logic [15:0] A_IN_TC_ADDR    = 16'h782c;
  localparam logic [15:0] A_OUT_TC_ADDR   = 16'h782d;
  localparam logic [15:0] A_LAUNCH_ADDR   = 16'h782e;
  localparam logic [15:0] B_LAUNCH_ADDR   = 16'h782f;
  localparam logic [15:0] B_IN_TC_ADDR    = 16'h7830;
  localparam logic [15:0] B_OUT_TC_ADDR   = 16'h7831;
  localparam logic [7:0]  WF_SEL_RESET    = 8'he4;
  localparam logic [7:0]  TC_RESET        = 8'h01;
  localparam int          DONE_BIT        = 7;
  localparam int          FLAG_OR_COUNT_SELECT_BIT        = 7;
  localparam int          SW_IDX_POS      = 6;
  localparam int          SR_IDX_POS      = 4;
  localparam int          FW_IDX_POS      = 2;
  localparam int          FR_IDX_POS      = 0;
  // burst kind, also the index of its count register and flag
  localparam logic [1:0]  KIND_A_IN       = 2'h0;
  localparam logic [1:0]  KIND_A_OUT      = 2'h1;
  localparam logic [1:0]  KIND_B_IN       = 2'h2;
  localparam logic [1:0]  KIND_B_OUT      = 2'h3;
  typedef enum logic [2:0] {
    PWT_IDLE,
    PWT_SGL_RD,
    PWT_SGL_WR,
    PWT_FIFO,
    PWT_GAP
  } pwt_state_t;
endpackage

//--- pwt_trigger_ctrl.sv
// trigger decode, burst sequencing and single-data registers of the waveform engine
//
// Operation
// R1: engine acts as master to slave fifos during its own transactions
// R2: exactly one of four programmable flags is the burst stop flag
// R3: read/write of a or b launch selects a_in, a_out, b_in, b_out flag
// R4: processor reads a fifo launch register to start a fifo read
// R5: processor fills fifo first, then writes its launch register
// R6: every fifo transaction completion is shown on done bit 7; the code sets done only when the whole burst ends
// R7: burst restarts automatically until stop flag or count ends it
// R8: count register bit 7 picks flag or count termination
// R9: each burst type has its own count register
// R10: a_in with select bit 1 repeats reads until stop flag sets
// R11: flag-terminated burst sets done when fifo reaches flag waterline
// R12: index register holds four 2-bit waveform indices per trigger type
// R13: index register resets to 11 10 01 00
// R14: high data register drives high lanes in 16-bit mode only
// R15: write of low trigger register launches single write with that byte
// R16: read of low trigger register launches single read, byte captured there
// R17: peek register is read-only mirror and never triggers
// R18: select bit 0 runs the burst for the lower 7-bit count
// R19: done rising raises engine-complete interrupt when enabled
// R20: trigger registered in one clock, indexed waveform starts, done clears
`timescale 1ns/100ps
module pwt_trigger_ctrl (
  // clock, reset, enable
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  // processor register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  // bus width and interrupt enable
  input  wire logic        wide_mode_in,
  input  wire logic        done_irq_en_in,
  output logic             done_irq_out,
  // slave fifo programmable flags
  input  wire logic        a_in_prog_flag_in,
  input  wire logic        a_out_prog_flag_in,
  input  wire logic        b_in_prog_flag_in,
  input  wire logic        b_out_prog_flag_in,
  // waveform executor handshake
  output logic             wave_start_out,
  output logic      [1:0]  wave_index_out,
  output logic             wave_is_fifo_out,
  output logic             wave_is_write_out,
  output logic             fifo_sel_b_out,
  output logic             burst_stop_flag_out,
  input  wire logic        wave_done_in,
  // single transaction data lanes
  output logic      [7:0]  data_bus_low_lanes_out,
  output logic      [7:0]  data_bus_high_lanes_out,
  input  wire logic [7:0]  data_bus_low_lanes_in,
  input  wire logic [7:0]  data_bus_high_lanes_in
);
  import pwt_pkg::*;

  logic       rst_s1_ff, rst_n_ff;
  logic [7:0] wf_sel_ff;
  logic [7:0] tc_ff [4];
  logic [7:0] dat_high_ff, dat_low_ff;
  logic       done_ff, done_d_ff;
  logic [1:0] kind_ff;
  logic [6:0] left_ff;
  logic       start_ff;
  logic [1:0] idx_ff;
  logic       is_fifo_ff, is_wr_ff;
  pwt_state_t state_ff, nxt_state;
  logic [7:0] rdata_ff;

  function automatic logic [1:0] idx_of(input logic [7:0] sel, input int pos);
    idx_of = sel[pos +: 2];
  endfunction

  // register address match, shared by every strobe decode except the count register writes
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] want);
    reg_hit = (addr == want);
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  logic is_idle, wr_wf, wr_hi, wr_lt, rd_lt, wr_a, rd_a, wr_b, rd_b, rd_capture;
  // launches need an idle engine; configuration writes are taken at any time
  assign is_idle = (state_ff == PWT_IDLE) && clk_en_in;
  assign wr_wf   = clk_en_in && reg_wr_in && reg_hit(reg_addr_in, WF_SEL_ADDR);
  assign wr_hi   = clk_en_in && reg_wr_in && reg_hit(reg_addr_in, DAT_HIGH_ADDR);
  assign wr_lt   = is_idle && reg_wr_in && reg_hit(reg_addr_in, DAT_LTRIG_ADDR);
  assign rd_lt   = is_idle && reg_rd_in && reg_hit(reg_addr_in, DAT_LTRIG_ADDR);
  assign wr_a    = is_idle && reg_wr_in && reg_hit(reg_addr_in, A_LAUNCH_ADDR);
  assign rd_a    = is_idle && reg_rd_in && reg_hit(reg_addr_in, A_LAUNCH_ADDR);
  assign wr_b    = is_idle && reg_wr_in && reg_hit(reg_addr_in, B_LAUNCH_ADDR);
  assign rd_b    = is_idle && reg_rd_in && reg_hit(reg_addr_in, B_LAUNCH_ADDR);
  // a single read ends with the executor's done pulse, lanes are valid then
  assign rd_capture = (state_ff == PWT_SGL_RD) && wave_done_in;

  logic fifo_trig, sgl_trig;
  logic [1:0] trig_kind;
  assign fifo_trig = wr_a || rd_a || wr_b || rd_b;
  assign sgl_trig  = wr_lt || rd_lt;
  // read launches are inbound kinds, writes outbound, b kinds sit above a
  assign trig_kind = {wr_b || rd_b, wr_a || wr_b};  // [R3]

  // burst stop flag chosen by the kind of the launching access
  always_comb begin
    case (kind_ff)  // [R2]
      KIND_A_IN:  burst_stop_flag_out = a_in_prog_flag_in;
      KIND_A_OUT: burst_stop_flag_out = a_out_prog_flag_in;
      KIND_B_IN:  burst_stop_flag_out = b_in_prog_flag_in;
      KIND_B_OUT: burst_stop_flag_out = b_out_prog_flag_in;
      default:    burst_stop_flag_out = 1'b0;
    endcase
  end

  logic use_flag, burst_over;
  assign use_flag   = tc_ff[kind_ff][FLAG_OR_COUNT_SELECT_BIT];  // [R8] [R9]
  // flag mode ends on the flag; count mode ends when remaining is one or zero
  assign burst_over = use_flag ? burst_stop_flag_out  // [R10] [R11]
                               : (left_ff <= 7'h01);  // [R18]

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PWT_IDLE: begin
        if (fifo_trig)
          nxt_state = PWT_FIFO;
        else if (rd_lt)
          nxt_state = PWT_SGL_RD;
        else if (wr_lt)
          nxt_state = PWT_SGL_WR;
      end
      PWT_SGL_RD, PWT_SGL_WR: begin
        if (wave_done_in)
          nxt_state = PWT_IDLE;
      end
      PWT_FIFO: begin
        if (wave_done_in)
          nxt_state = burst_over ? PWT_IDLE : PWT_GAP;  // [R7]
      end
      PWT_GAP:  nxt_state = PWT_FIFO;
      default:  nxt_state = PWT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff)
      state_ff <= PWT_IDLE;
    else if (clk_en_in)
      state_ff <= nxt_state;
  end

  // waveform launch: one pulse per transaction, index from the select register
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      start_ff   <= 1'b0;
      idx_ff     <= 2'h0;
      is_fifo_ff <= 1'b0;
      is_wr_ff   <= 1'b0;
    end else if (clk_en_in) begin
      start_ff <= 1'b0;
      if (fifo_trig) begin  // [R20] [R1] [R4] [R5]
        start_ff   <= 1'b1;
        is_fifo_ff <= 1'b1;
        is_wr_ff   <= trig_kind[0];
        idx_ff     <= trig_kind[0] ? idx_of(wf_sel_ff, FW_IDX_POS)
                                   : idx_of(wf_sel_ff, FR_IDX_POS);  // [R12]
      end else if (sgl_trig) begin  // [R20]
        start_ff   <= 1'b1;
        is_fifo_ff <= 1'b0;
        is_wr_ff   <= wr_lt;
        idx_ff     <= wr_lt ? idx_of(wf_sel_ff, SW_IDX_POS)
                            : idx_of(wf_sel_ff, SR_IDX_POS);
      end else if (state_ff == PWT_GAP) begin
        start_ff <= 1'b1;  // [R7]
      end
    end
  end

  // burst kind and remaining count
  // the count is loaded at launch, but a later count write still changes the bit 7 flag or count select of the running burst
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      kind_ff <= KIND_A_IN;
      left_ff <= 7'h01;
    end else if (clk_en_in) begin
      if (fifo_trig) begin
        kind_ff <= trig_kind;  // [R3]
        left_ff <= tc_ff[trig_kind][6:0];  // [R18]
      end else if (state_ff == PWT_FIFO && wave_done_in && left_ff != 7'h00) begin
        left_ff <= left_ff - 7'h01;
      end
    end
  end

  // done bit: clears on launch, sets when the whole transaction or burst ends
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      done_ff   <= 1'b1;
      done_d_ff <= 1'b1;
    end else if (clk_en_in) begin
      done_d_ff <= done_ff;
      if (fifo_trig || sgl_trig)
        done_ff <= 1'b0;  // [R20]
      else if (state_ff != PWT_IDLE && nxt_state == PWT_IDLE)
        done_ff <= 1'b1;  // [R6] [R11]
    end
  end

  assign done_irq_out = done_irq_en_in && done_ff && !done_d_ff;  // [R19]

  // waveform index select
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff)
      wf_sel_ff <= WF_SEL_RESET;  // [R13]
    else if (wr_wf)
      wf_sel_ff <= reg_wdata_in;  // [R12]
  end

  // transaction count registers
  // one register per burst kind, indexed by the kind code
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < 4; i++)
        tc_ff[i] <= TC_RESET;
    end else if (clk_en_in && reg_wr_in) begin
      case (reg_addr_in)
        A_IN_TC_ADDR:  tc_ff[KIND_A_IN] <= reg_wdata_in;  // [R9]
        A_OUT_TC_ADDR: tc_ff[KIND_A_OUT] <= reg_wdata_in;
        B_IN_TC_ADDR:  tc_ff[KIND_B_IN] <= reg_wdata_in;
        B_OUT_TC_ADDR: tc_ff[KIND_B_OUT] <= reg_wdata_in;
        default:       ;
      endcase
    end
  end

  // high single data: processor write, or upper lanes of a wide single read
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dat_high_ff <= 8'h00;
    end else if (clk_en_in) begin
      if (rd_capture && wide_mode_in)
        dat_high_ff <= data_bus_high_lanes_in;  // [R14]
      else if (wr_hi)
        dat_high_ff <= reg_wdata_in;
    end
  end

  // low single data: byte to send, or byte captured by a single read
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      dat_low_ff <= 8'h00;
    end else if (clk_en_in) begin
      if (rd_capture)
        dat_low_ff <= data_bus_low_lanes_in;  // [R16]
      else if (wr_lt)
        dat_low_ff <= reg_wdata_in;  // [R15]
    end
  end

  assign data_bus_low_lanes_out  = dat_low_ff;
  assign data_bus_high_lanes_out = wide_mode_in ? dat_high_ff : 8'h00;  // [R14]

  // read mux: unmapped addresses and the launch registers read as zero
  logic [7:0] nxt_rdata;
  always_comb begin
    case (reg_addr_in)
      WF_SEL_ADDR:    nxt_rdata = wf_sel_ff;
      IDLE_CS_ADDR:   nxt_rdata = {done_ff, 7'h00};  // [R6]
      DAT_HIGH_ADDR:  nxt_rdata = dat_high_ff;
      DAT_LTRIG_ADDR: nxt_rdata = dat_low_ff;  // [R16]
      DAT_LPEEK_ADDR: nxt_rdata = dat_low_ff;  // [R17]
      A_IN_TC_ADDR:   nxt_rdata = tc_ff[KIND_A_IN];
      A_OUT_TC_ADDR:  nxt_rdata = tc_ff[KIND_A_OUT];
      B_IN_TC_ADDR:   nxt_rdata = tc_ff[KIND_B_IN];
      B_OUT_TC_ADDR:  nxt_rdata = tc_ff[KIND_B_OUT];
      default:        nxt_rdata = 8'h00;
    endcase
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge ref_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff)
      rdata_ff <= 8'h00;
    else if (clk_en_in && reg_rd_in)
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata_out     = rdata_ff;
  assign wave_start_out    = start_ff;
  assign wave_index_out    = idx_ff;
  assign wave_is_fifo_out  = is_fifo_ff;
  assign wave_is_write_out = is_wr_ff;
  assign fifo_sel_b_out    = kind_ff[1];
endmodule

//--- pwt_trigger_ctrl_asserts.sv
// port checker for the waveform trigger block
`timescale 1ns/100ps
module pwt_trigger_ctrl_asserts
  import pwt_pkg::*;
(
  // clock, reset, register port, modes
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        clk_en_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        wide_mode_in,
  input wire logic        done_irq_en_in,
  input wire logic        done_irq_out,
  // flags, executor, lanes
  input wire logic        a_in_prog_flag_in,
  input wire logic        a_out_prog_flag_in,
  input wire logic        b_in_prog_flag_in,
  input wire logic        b_out_prog_flag_in,
  input wire logic        wave_start_out,
  input wire logic [1:0]  wave_index_out,
  input wire logic        wave_is_fifo_out,
  input wire logic        wave_is_write_out,
  input wire logic        fifo_sel_b_out,
  input wire logic        burst_stop_flag_out,
  input wire logic        wave_done_in,
  input wire logic [7:0]  data_bus_low_lanes_out,
  input wire logic [7:0]  data_bus_high_lanes_out
);
  logic [7:0] sel_ff;
  logic [7:0] idx_v;
  logic [1:0] up_ff;
  logic       pend_ff;
  logic       dd_ff;
  logic       idle_ok;
  logic       flag_v;
  assign idle_ok = up_ff == 2'h3 && !pend_ff && !wave_done_in && !dd_ff;
  assign idx_v = sel_ff >> {!wave_is_fifo_out, wave_is_write_out, 1'b0};
  assign flag_v = fifo_sel_b_out ? (wave_is_write_out ? b_out_prog_flag_in : b_in_prog_flag_in)
                                 : (wave_is_write_out ? a_out_prog_flag_in : a_in_prog_flag_in);
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_ff  <= WF_SEL_RESET;
      up_ff   <= 2'h0;
      pend_ff <= 1'b0;
      dd_ff   <= 1'b0;
    end else begin
      up_ff   <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
      pend_ff <= wave_start_out | (pend_ff & ~wave_done_in);
      dd_ff   <= wave_done_in;
      if (clk_en_in && reg_wr_in && reg_addr_in == WF_SEL_ADDR) begin
        sel_ff <= reg_wdata_in;
      end
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_take(a, rd);
    clk_en_in && idle_ok && reg_addr_in == a && (rd ? reg_rd_in : reg_wr_in);
  endsequence
  sequence s_go(f, w, b);
    wave_start_out && wave_is_fifo_out == f && wave_is_write_out == w &&
      (!f || fifo_sel_b_out == b);
  endsequence
  property p_a_rd; s_take(A_LAUNCH_ADDR, 1'b1) |=> s_go(1'b1, 1'b0, 1'b0); endproperty
  property p_b_wr; s_take(B_LAUNCH_ADDR, 1'b0) |=> s_go(1'b1, 1'b1, 1'b1); endproperty
  property p_s_rd; s_take(DAT_LTRIG_ADDR, 1'b1) |=> s_go(1'b0, 1'b0, 1'b0); endproperty
  property p_s_wr;
    s_take(DAT_LTRIG_ADDR, 1'b0) |=>
      s_go(1'b0, 1'b1, 1'b0) ##0 (data_bus_low_lanes_out == $past(reg_wdata_in));
  endproperty
  property p_peek; s_take(DAT_LPEEK_ADDR, 1'b1) |=> !wave_start_out; endproperty
  property p_idx; wave_start_out |-> wave_index_out == idx_v[1:0]; endproperty
  property p_flag; wave_is_fifo_out |-> burst_stop_flag_out == flag_v; endproperty
  property p_high;
    !wide_mode_in && $past(wide_mode_in) == 1'b0 |-> data_bus_high_lanes_out == 8'h00;
  endproperty
  property p_irq; done_irq_out |-> done_irq_en_in && (dd_ff || $past(dd_ff)); endproperty
  a_a_rd: assert property (p_a_rd) else $error("fifo a read launch");
  a_b_wr: assert property (p_b_wr) else $error("fifo b write launch");
  a_s_rd: assert property (p_s_rd) else $error("single read launch");
  a_s_wr: assert property (p_s_wr) else $error("single write launch");
  a_peek: assert property (p_peek) else $error("peek read launched");
  a_idx: assert property (p_idx) else $error("wave index");
  a_flag: assert property (p_flag) else $error("stop flag select");
  a_high: assert property (p_high) else $error("high lanes in narrow mode");
  a_irq: assert property (p_irq) else $error("irq pulse");
endmodule

//--- test_parallel_waveform_trigger_ctrl.sv
// self-checking bench for the waveform trigger block
`timescale 1ns/100ps
module test_parallel_waveform_trigger_ctrl;
  import pwt_pkg::*;
  logic        ref_clk_in, nrst_in, clk_en_in, reg_wr_in, reg_rd_in, wide_mode_in, took;
  logic        done_irq_en_in, done_irq_out, a_in_prog_flag_in, a_out_prog_flag_in, clr;
  logic        b_in_prog_flag_in, b_out_prog_flag_in, wave_start_out, wave_is_fifo_out;
  logic        wave_is_write_out, fifo_sel_b_out, burst_stop_flag_out, wave_done_in;
  logic [1:0]  wave_index_out;
  logic [2:0]  lat;
  logic [6:0]  lim;
  logic [7:0]  reg_wdata_in, reg_rdata_out, sel, data_bus_low_lanes_out;
  logic [7:0]  data_bus_high_lanes_out, data_bus_low_lanes_in, data_bus_high_lanes_in;
  logic [8:0]  ent;
  logic [15:0] reg_addr_in, cap, d;
  logic [8:0]  rq[$];
  logic [7:0]  sq[$];
  int          error_cnt, n_compared, irq_cnt, seed;
  pwt_trigger_ctrl DUT (.*);
  pwt_fifo_model u_far (.clk_in(ref_clk_in), .start_in(wave_start_out),
    .fifo_in(wave_is_fifo_out), .kind_in({fifo_sel_b_out, wave_is_write_out}), .lat_in(lat),
    .done_out(wave_done_in), .lim_in(lim), .clr_in(clr), .flags_out({b_out_prog_flag_in,
    b_in_prog_flag_in, a_out_prog_flag_in, a_in_prog_flag_in}), .cap_out(cap),
    .lo_out(data_bus_low_lanes_in), .hi_out(data_bus_high_lanes_in));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] v, input logic c);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = rd;
    reg_wr_in = !rd;
    reg_wdata_in = v;
    if (rd) rq.push_back({c, v});
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    reg_wr_in = 1'b0;
  endtask
  task automatic final_report();
    check("queue", 8'(sq.size()), 8'h00);
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 1000; i++) begin
      acc(1'b1, IDLE_CS_ADDR, 8'h00, 1'b0);
      if (reg_rdata_out[DONE_BIT] === 1'b1) return;
    end
    error_cnt++;
    final_report();
  endtask
  task automatic burst(input logic [1:0] k, input logic [7:0] tc, input int n);
    logic [15:0] ta[4] = '{A_IN_TC_ADDR, A_OUT_TC_ADDR, B_IN_TC_ADDR, B_OUT_TC_ADDR};
    lat = 3'(1 + $urandom % 4);
    done_irq_en_in = k[0];
    irq_cnt = 0;
    clr = 1'b1;
    acc(1'b0, ta[k], tc, 1'b0);
    clr = 1'b0;
    repeat (n) sq.push_back({4'h1, k[0], k[1], 2'(sel >> {k[0], 1'b0})});
    acc(!k[0], k[1] ? B_LAUNCH_ADDR : A_LAUNCH_ADDR, 8'h00, 1'b1);
    // a second launch while busy is dropped
    acc(1'b1, A_LAUNCH_ADDR, 8'h00, 1'b1);
    wait_done();
    check("irq", 8'(irq_cnt), {7'h0, k[0]});
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) took <= reg_rd_in & clk_en_in;
  always @(negedge ref_clk_in) begin
    if (took === 1'b1 && rq.size() != 0) begin
      ent = rq.pop_front();
      if (ent[8]) check("rdata", reg_rdata_out, ent[7:0]);
    end
    if (wave_start_out === 1'b1) begin
      check("start", {3'h0, wave_is_fifo_out, wave_is_write_out, fifo_sel_b_out, wave_index_out},
            sq.size() != 0 ? sq.pop_front() : 8'hff);
    end
    if (done_irq_out === 1'b1) irq_cnt++;
  end
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, wide_mode_in, done_irq_en_in, clr} = 6'h0;
    clk_en_in = 1'b1;
    reg_addr_in = 16'h0;
    reg_wdata_in = 8'h0;
    lat = 3'h1;
    lim = 7'h1;
    seed = $urandom(32'hb42f);
    repeat (2) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    acc(1'b1, WF_SEL_ADDR, WF_SEL_RESET, 1'b1);
    acc(1'b1, IDLE_CS_ADDR, 8'h80, 1'b1);
    acc(1'b1, B_OUT_TC_ADDR, TC_RESET, 1'b1);
    acc(1'b1, 16'h7826, 8'h00, 1'b1);
    $display("test reset ended");
    sel = 8'($urandom);
    acc(1'b0, WF_SEL_ADDR, sel, 1'b0);
    clk_en_in = 1'b0;
    acc(1'b0, WF_SEL_ADDR, ~sel, 1'b0);
    clk_en_in = 1'b1;
    acc(1'b1, WF_SEL_ADDR, sel, 1'b1);
    $display("test index ended");
    for (int k = 0; k < 4; k++) begin
      burst(2'(k), (k == 3) ? 8'h7f : 8'(k), (k == 3) ? 127 : ((k == 0) ? 1 : k));
    end
    lim = 7'(3 + $urandom % 3);
    burst(KIND_A_IN, 8'h81, int'(lim));
    check("stop flag", {7'h0, burst_stop_flag_out}, 8'h01);
    $display("test bursts ended");
    for (int w = 0; w < 2; w++) begin
      wide_mode_in = w[0];
      d = 16'($urandom);
      acc(1'b0, DAT_HIGH_ADDR, d[15:8], 1'b0);
      sq.push_back({6'h02, sel[7:6]});
      acc(1'b0, DAT_LTRIG_ADDR, d[7:0], 1'b0);
      wait_done();
      check("low lanes", data_bus_low_lanes_out, d[7:0]);
      check("high lanes", data_bus_high_lanes_out, w ? d[15:8] : 8'h00);
      sq.push_back({6'h00, sel[5:4]});
      acc(1'b1, DAT_LTRIG_ADDR, 8'h00, 1'b0);
      wait_done();
      acc(1'b0, DAT_LPEEK_ADDR, ~cap[7:0], 1'b0);
      acc(1'b1, DAT_LPEEK_ADDR, cap[7:0], 1'b1);
      if (w) acc(1'b1, DAT_HIGH_ADDR, cap[15:8], 1'b1);
      sq.push_back({6'h00, sel[5:4]});
      acc(1'b1, DAT_LTRIG_ADDR, cap[7:0], 1'b1);
      wait_done();
    end
    $display("test single ended");
    final_report();
  end
endmodule
bind pwt_trigger_ctrl pwt_trigger_ctrl_asserts u_chk (.*);
